// >>> rapc_demod_model.sv
`timescale 1ns/1ns
module rapc_demod_model
    import rapc_pkg::*;
(
    input  wire logic      clock_i,
    output rapc_demod_type demod_o
);
    // preamble pulls one way and all that follows the other, so a correction
    // that keeps tracking past preamble detect ends on the opposite bound
    localparam logic [OFS_W-1:0] ERR_UP   = 10'h07F;
    localparam logic [OFS_W-1:0] ERR_DOWN = 10'h380;
    initial demod_o = '0;
    task automatic tick(input rapc_demod_type v);
        @(posedge clock_i);
        demod_o <= v;
    endtask : tick
    // data line inverts between bits so a stale bit never looks valid
    task automatic send_byte(input logic [7:0] b, input logic [OFS_W-1:0] err);
        for (int i = 7; i >= 0; i--) begin
            tick('{1'b1, b[i], 1'b0, 1'b0, err});
            tick('{1'b0, ~b[i], 1'b0, 1'b0, err});
        end
    endtask : send_byte
    task automatic frame(input logic pre_ok, input logic [7:0] d[$]);
        repeat (5) send_byte(8'hAA, ERR_UP);
        tick('{1'b0, 1'b0, pre_ok, 1'b0, ERR_DOWN});
        send_byte(8'h2D, ERR_DOWN);
        send_byte(8'hD4, ERR_DOWN);
        tick('{1'b0, 1'b0, 1'b0, 1'b1, ERR_DOWN});
        foreach (d[i]) send_byte(d[i], ERR_DOWN);
    endtask : frame
endmodule : rapc_demod_model

// >>> rapc_pkg.sv
package rapc_pkg;
    localparam int OFS_W       = 10;
    localparam int LIM_W       = 8;
    localparam int GAIN_W      = 4;
    localparam int RSSI_W      = 8;
    localparam int CRC_W       = 16;
    localparam int CNT_W       = 16;
    localparam logic [OFS_W-1:0]   OFS_RST   = 10'h000;
    localparam logic [CRC_W-1:0]   CRC_INIT  = 16'hFFFF;
    localparam logic [CRC_W-1:0]   CRC_POLY  = 16'h8005;
    localparam logic [GAIN_W-1:0]  PGA_MAX   = 4'hF;
    localparam logic [GAIN_W-1:0]  PGA_MIN   = 4'h0;
    localparam logic [RSSI_W-1:0]  RSSI_HI   = 8'hC0;
    localparam logic [RSSI_W-1:0]  RSSI_LO   = 8'h40;
    localparam logic [2:0]         BIT_LAST  = 3'h7;
    localparam logic [CNT_W-1:0]   CNT_ONE   = 16'h0001;

    typedef enum logic [1:0] {
        RAPC_IDLE = 2'b00,
        RAPC_PRE  = 2'b01,
        RAPC_SYNC = 2'b11,
        RAPC_DATA = 2'b10
    } rapc_state_type;

    // packet handler configuration from the host
    typedef struct packed {
        logic             afc_en;
        logic             pkt_handler_en;
        logic             multi_packet;
        logic             crc_en;
        logic [1:0]       exit_state;
        logic [CNT_W-1:0] header_len;
        logic [CNT_W-1:0] payload_len;
    } rapc_cfg_type;

    // demodulator side
    typedef struct packed {
        logic             bit_valid;
        logic             bit_data;
        logic             preamble_det;
        logic             sync_match;
        logic [OFS_W-1:0] freq_err;
    } rapc_demod_type;

    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } rapc_byte_type;
endpackage : rapc_pkg

// >>> rapc_rx_control.sv
// Operation
// R1 - with correction enabled, steer synthesizer by detected carrier offset
// R2 - freeze correction after preamble detect until packet end
// R3 - multi-packet: clear correction at packet end, reacquire next packet
// R4 - clamp correction magnitude to unsigned pull-in limit when enabled
// R5 - transmitter sends about 40 preamble bits with correction, 32 without
// R6 - packet handler off: every byte after sync goes to FIFO
// R7 - packet handler on: only payload bytes stored, other fields dropped
// R8 - host programs preamble and sync; FIFO fills only after both
// R9 - mirror demodulated bits on pin in real time
// R10 - FIFO mode: leave receive on packet-valid, go to configured state
// R11 - packet valid clears receive-on unless multi-packet set
// R12 - multi-packet set: stay in receive after good packet
// R13 - host picks next action in multi-packet from interrupts
// R14 - sync detection disabled until preamble detected
// R15 - gain loop: one LNA step, PGA in 3 dB steps
// R16 - signal strength reported in 0.5 dB steps
// R17 - check CRC of each packet, flag failures
// R18 - manual offset used when correction off, correction otherwise
// R19 - correction signed, same units as manual offset, saturates at limit
`timescale 1ns/1ns
module rapc_rx_control
    import rapc_pkg::*;
(
    input  wire logic                clock_i,
    input  wire logic                rst_n_i,
    input  wire rapc_cfg_type        cfg_i,
    input  wire logic [OFS_W-1:0]    manual_freq_offset_i,
    input  wire logic [LIM_W-1:0]    afc_pull_in_limit_i,
    input  wire logic                rx_on_set_i,
    input  wire rapc_demod_type      demod_i,
    input  wire logic [RSSI_W-1:0]   rssi_raw_i,
    output logic [OFS_W-1:0]         synth_offset_o,
    output rapc_byte_type            fifo_wr_o,
    output logic                     rx_bitstream_mirror_o,
    output logic                     rx_on_o,
    output logic [1:0]               next_mode_o,
    output logic                     packet_valid_o,
    output logic                     crc_error_o,
    output logic                     lna_high_o,
    output logic [GAIN_W-1:0]        pga_step_o,
    output logic [RSSI_W-1:0]        rssi_half_db_o
);
    rapc_state_type   state;
    rapc_state_type   next_state;
    logic [OFS_W-1:0] afc_value;
    logic [OFS_W-1:0] next_afc;
    logic [2:0]       bit_cnt;
    logic [7:0]       shreg;
    logic [CNT_W-1:0] byte_cnt;
    logic [CRC_W-1:0] crc;

    // signed clamp; limit is unsigned so it is zero-extended before negation
    wire logic signed [OFS_W:0] lim_s    = {{(OFS_W+1-LIM_W){1'b0}}, afc_pull_in_limit_i};
    wire logic signed [OFS_W:0] err_s    = {demod_i.freq_err[OFS_W-1], demod_i.freq_err};
    // one guard bit is enough: the held value never exceeds the 8-bit limit
    wire logic signed [OFS_W:0] acc_s    = (OFS_W+1)'({afc_value[OFS_W-1], afc_value} + err_s);
    // limitation: a zero limit pins the correction at zero
    wire logic signed [OFS_W:0] clamp_s  = (acc_s > lim_s) ? lim_s : ((acc_s < -lim_s) ? -lim_s : acc_s); // R4 R19
    // tracking stops at preamble detect and stays off until the packet ends
    wire logic                  tracking = cfg_i.afc_en && rx_on_o && (state == RAPC_IDLE || state == RAPC_PRE); // R1 R2

    wire logic                  byte_done = demod_i.bit_valid && (bit_cnt == BIT_LAST) && (state == RAPC_DATA);
    wire logic [7:0]            byte_val = {shreg[6:0], demod_i.bit_data};
    // header bytes are still counted so the packet end lands on the right byte
    wire logic [CNT_W-1:0]      pkt_len  = cfg_i.pkt_handler_en ? CNT_W'(cfg_i.header_len + cfg_i.payload_len)
                                                                 : cfg_i.payload_len;
    wire logic                  in_payload = !cfg_i.pkt_handler_en || (byte_cnt >= cfg_i.header_len); // R7
    wire logic                  pkt_end  = byte_done && (byte_cnt + CNT_ONE == pkt_len);
    // the appended check bytes run through the same register, so a clean packet leaves zero
    wire logic                  crc_fb   = crc[CRC_W-1] ^ demod_i.bit_data;
    wire logic [CRC_W-1:0]      crc_next = {crc[CRC_W-2:0], 1'b0} ^ (crc_fb ? CRC_POLY : '0);
    wire logic                  crc_bad  = cfg_i.crc_en && (crc_next != '0);
    wire logic                  pkt_good = pkt_end && !crc_bad;
    // a failed check keeps receive on, the host decides what follows
    wire logic                  rx_exit  = pkt_good && !cfg_i.multi_packet; // R11 R12
    // shared register: manual value only while correction is off
    wire logic [OFS_W-1:0]      synth_sel = cfg_i.afc_en ? next_afc : manual_freq_offset_i; // R18
    wire logic                  too_strong = rssi_raw_i > RSSI_HI;
    wire logic                  too_weak   = rssi_raw_i < RSSI_LO;

    always_comb begin
        next_afc = afc_value;
        if (!cfg_i.afc_en) begin
            next_afc = OFS_RST;
        end else if (pkt_end && cfg_i.multi_packet) begin
            next_afc = OFS_RST; // R3
        end else if (tracking && demod_i.bit_valid) begin
            next_afc = clamp_s[OFS_W-1:0]; // R1
        end
    end

    always_comb begin
        next_state = state;
        case (state)
            RAPC_IDLE: begin
                if (rx_on_o) begin
                    next_state = RAPC_PRE;
                end
            end
            RAPC_PRE: begin
                if (!rx_on_o) begin
                    next_state = RAPC_IDLE;
                end else if (demod_i.preamble_det) begin
                    next_state = RAPC_SYNC; // R2 R14
                end
            end
            RAPC_SYNC: begin
                if (!rx_on_o) begin
                    next_state = RAPC_IDLE;
                end else if (demod_i.sync_match) begin
                    next_state = RAPC_DATA; // R8
                end
            end
            default: begin
                if (pkt_end) begin
                    next_state = RAPC_PRE;
                end
            end
        endcase
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            state     <= RAPC_IDLE;
            afc_value <= OFS_RST;
        end else begin
            state     <= next_state;
            afc_value <= next_afc;
        end
    end

    // the shared synthesizer offset register: manual value only while correction off
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            synth_offset_o <= OFS_RST;
        end else begin
            synth_offset_o <= synth_sel; // R18
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            bit_cnt  <= '0;
            shreg    <= '0;
            byte_cnt <= '0;
            crc      <= CRC_INIT;
        end else if (state != RAPC_DATA) begin
            bit_cnt  <= '0;
            byte_cnt <= '0;
            crc      <= CRC_INIT;
        end else if (demod_i.bit_valid) begin
            bit_cnt <= bit_cnt + 3'h1;
            shreg   <= byte_val;
            crc     <= crc_next; // R17
            if (byte_done) begin
                byte_cnt <= byte_cnt + CNT_ONE;
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            fifo_wr_o <= '0;
        end else begin
            fifo_wr_o.valid <= byte_done && in_payload; // R6 R7
            fifo_wr_o.data  <= byte_val;
        end
    end

    // mirror is unconditional, so it keeps running while the FIFO fills
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            rx_bitstream_mirror_o <= 1'b0;
        end else if (demod_i.bit_valid) begin
            rx_bitstream_mirror_o <= demod_i.bit_data; // R9
        end
    end

    // host set of receive-on loses only to a same-cycle good packet end with multi-packet off
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            rx_on_o        <= 1'b0;
            next_mode_o    <= 2'b00;
            packet_valid_o <= 1'b0;
            crc_error_o    <= 1'b0;
        end else begin
            packet_valid_o <= pkt_good;
            crc_error_o    <= pkt_end && crc_bad; // R17
            if (rx_exit) begin
                rx_on_o     <= 1'b0; // R10 R11
                next_mode_o <= cfg_i.exit_state; // R10
            end else if (rx_on_set_i) begin
                rx_on_o     <= 1'b1; // R12
            end
        end
    end

    // coarse gain loop: too strong steps PGA down one 3 dB code per step before the LNA single step; too weak restores LNA first, then PGA
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            lna_high_o     <= 1'b1;
            pga_step_o     <= PGA_MAX;
            rssi_half_db_o <= '0;
        end else begin
            rssi_half_db_o <= rssi_raw_i; // R16
            if (too_strong) begin
                if (pga_step_o != PGA_MIN) begin
                    pga_step_o <= pga_step_o - 4'h1; // R15
                end else begin
                    lna_high_o <= 1'b0; // R15
                end
            end else if (too_weak) begin
                if (!lna_high_o) begin
                    lna_high_o <= 1'b1;
                end else if (pga_step_o != PGA_MAX) begin
                    pga_step_o <= pga_step_o + 4'h1;
                end
            end
        end
    end
endmodule : rapc_rx_control

// >>> rapc_rx_control_props.sv
`timescale 1ns/1ns
module rapc_rx_control_props
    import rapc_pkg::*;
(
    input wire logic              clock_i,
    input wire logic              rst_n_i,
    input wire logic              rx_on_set_i,
    input wire logic              rx_bitstream_mirror_o,
    input wire logic              rx_on_o,
    input wire logic              packet_valid_o,
    input wire logic              crc_error_o,
    input wire logic              lna_high_o,
    input wire rapc_cfg_type      cfg_i,
    input wire rapc_demod_type    demod_i,
    input wire rapc_byte_type     fifo_wr_o,
    input wire logic [OFS_W-1:0]  manual_freq_offset_i,
    input wire logic [OFS_W-1:0]  synth_offset_o,
    input wire logic [LIM_W-1:0]  afc_pull_in_limit_i,
    input wire logic [RSSI_W-1:0] rssi_raw_i,
    input wire logic [RSSI_W-1:0] rssi_half_db_o,
    input wire logic [GAIN_W-1:0] pga_step_o,
    input wire logic [1:0]        next_mode_o
);
    wire signed [OFS_W-1:0] ofs = synth_offset_o;
    wire signed [OFS_W-1:0] lim = {2'b00, afc_pull_in_limit_i};
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    chk_manual_offset: assert property ($past(rst_n_i && !cfg_i.afc_en) |->
        synth_offset_o == $past(manual_freq_offset_i)) else $error("manual offset not applied");
    chk_offset_limit: assert property ($past(rst_n_i && cfg_i.afc_en) |->
        ofs <= lim && ofs >= -lim) else $error("correction beyond limit");
    // the last stored byte meets the multi-packet clear, so only earlier bytes must see it frozen
    chk_data_frozen: assert property (fifo_wr_o.valid && !packet_valid_o && !crc_error_o |-> $stable(synth_offset_o))
        else $error("correction moved during data");
    chk_mirror_bit: assert property (demod_i.bit_valid |=>
        rx_bitstream_mirror_o == $past(demod_i.bit_data)) else $error("mirror bit wrong");
    chk_single_exit: assert property (packet_valid_o && !cfg_i.multi_packet |->
        ##[0:1] !rx_on_o && next_mode_o == cfg_i.exit_state) else $error("no exit after packet");
    chk_multi_stay: assert property (packet_valid_o && cfg_i.multi_packet |-> rx_on_o [*3])
        else $error("receive left in multi mode");
    chk_crc_verdict: assert property (packet_valid_o |-> !crc_error_o ##1 !packet_valid_o)
        else $error("verdict pulse wrong");
    chk_rssi_copy: assert property ($past(rst_n_i) |-> rssi_half_db_o == $past(rssi_raw_i))
        else $error("strength not reported");
    chk_pga_step: assert property ($past(rst_n_i) && $changed(pga_step_o) |->
        4'(pga_step_o - $past(pga_step_o)) inside {4'h1, 4'hF}) else $error("gain jumped");
    cover property (packet_valid_o && cfg_i.multi_packet);
    cover property (crc_error_o);
    cover property (fifo_wr_o.valid && cfg_i.pkt_handler_en);
endmodule : rapc_rx_control_props

// >>> rapc_rx_control_tb_top.sv
`timescale 1ns/1ns
module rapc_rx_control_tb_top;
    import rapc_pkg::*;
    logic clock_i = 1'b0, rst_n_i = 1'b0, rx_on_set_i = 1'b0;
    rapc_cfg_type cfg_i = '0;
    logic [OFS_W-1:0] manual_freq_offset_i = 10'h360, synth_offset_o, off_seen;
    logic [LIM_W-1:0] afc_pull_in_limit_i = 8'h08;
    logic [RSSI_W-1:0] rssi_raw_i = 8'h80, rssi_half_db_o;
    rapc_demod_type demod_i;
    rapc_byte_type fifo_wr_o;
    logic rx_bitstream_mirror_o, rx_on_o, packet_valid_o, crc_error_o, lna_high_o;
    logic [GAIN_W-1:0] pga_step_o;
    logic [1:0] next_mode_o;
    int fails = 0, checked = 0, pv, ce;
    logic [7:0] got[$];
    always #10 clock_i = ~clock_i;
    rapc_demod_model rapc_demod_model_i (.clock_i(clock_i), .demod_o(demod_i));
    rapc_rx_control rapc_rx_control_i (.*);
    always @(posedge clock_i) begin
        if (fifo_wr_o.valid === 1'b1 && got.size() == 0) off_seen <= synth_offset_o;
        if (fifo_wr_o.valid === 1'b1) got.push_back(fifo_wr_o.data);
        pv += int'(packet_valid_o === 1'b1);
        ce += int'(crc_error_o === 1'b1);
    end
    task automatic check(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e) begin
            fails++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : check
    function automatic logic [15:0] crc16(input logic [7:0] d[$]);
        logic [15:0] c = CRC_INIT;
        foreach (d[i])
            for (int b = 7; b >= 0; b--)
                c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i][b]) ? CRC_POLY : 16'h0000);
        return c;
    endfunction : crc16
    task automatic packet(input logic pre, input logic [7:0] d[$], input int hdr);
        got.delete();
        pv = 0;
        ce = 0;
        @(posedge clock_i) rx_on_set_i <= 1'b1;
        @(posedge clock_i) rx_on_set_i <= 1'b0;
        rapc_demod_model_i.frame(pre, d);
        repeat (4) @(posedge clock_i);
        check(32'(got.size()), pre ? 32'(d.size() - hdr) : 32'h0);
        foreach (got[i]) check(32'(got[i]), 32'(d[i + hdr]));
        check(32'(rx_bitstream_mirror_o), 32'(d[d.size() - 1][0]));
    endtask : packet
    task automatic report_and_stop();
        $display("checked=%0d fails=%0d", checked, fails);
        if (fails == 0 && checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : report_and_stop
    initial begin
        logic [7:0] d[$];
        logic [15:0] c;
        repeat (16) @(posedge clock_i);
        check(32'({lna_high_o, pga_step_o, rx_on_o}), 32'({1'b1, PGA_MAX, 1'b0}));
        rst_n_i <= 1'b1;
        d = '{8'h11, 8'h22, 8'h33};
        cfg_i.payload_len <= 16'h0003;
        packet(1'b0, d, 0);
        for (int e = 1; e < 4; e++) begin
            cfg_i.exit_state <= 2'(e);
            packet(1'b1, d, 0);
            check(32'(pv), 32'h1);
            check(32'(next_mode_o), 32'(e));
            check(32'(rx_on_o), 32'h0);
            check(32'(synth_offset_o), 32'(manual_freq_offset_i));
        end
        d = '{8'hE7, 8'h5A, 8'hC3};
        c = crc16(d);
        d.push_back(c[15:8]);
        d.push_back(c[7:0]);
        cfg_i <= '{1'b1, 1'b1, 1'b1, 1'b1, 2'h1, 16'h0001, 16'h0004};
        packet(1'b1, d, 1);
        check(32'(pv), 32'h1);
        check(32'(rx_on_o), 32'h1);
        check(32'(off_seen), 32'(afc_pull_in_limit_i));
        check(32'(synth_offset_o), 32'h0);
        d[2] = ~d[2];
        packet(1'b1, d, 1);
        check(32'({ce[7:0], pv[7:0]}), 32'h0100);
        rssi_raw_i <= 8'hE0;
        repeat (40) @(posedge clock_i);
        check(32'(rssi_half_db_o), 32'hE0);
        check(32'({lna_high_o, pga_step_o}), 32'({1'b0, PGA_MIN}));
        report_and_stop();
    end
    // well above the roughly 1070 cycles the packets need
    initial begin
        repeat (8000) @(posedge clock_i);
        fails++;
        report_and_stop();
    end
endmodule : rapc_rx_control_tb_top
bind rapc_rx_control rapc_rx_control_props rapc_rx_control_props_i (.*);
